// ---- inc/rcw_consts.svh ----
// Constants of the radio control word block: field positions, reset values, timing.
// Included by the package and design files; definitions only.
`ifndef RCW_CONSTS_SVH
`define RCW_CONSTS_SVH
`define RCW_WORD_W 32
`define RCW_RAMP_BIT 19
`define RCW_DCX_MODE_BIT 18
`define RCW_REF_HI_BIT 14
`define RCW_REF_LO_BIT 13
`define RCW_LVL_HI 12
`define RCW_LVL_LO 10
`define RCW_HOLD_BIT 9
`define RCW_RX_BIT 8
`define RCW_CHAN_HI 7
`define RCW_CHAN_LO 0
`define RCW_WORD_RST 32'h0000_0000
`define RCW_STROBE_IDLE 1'b1
`define RCW_DIV_BASE 12'h900
`define RCW_REFDIV_12 4'hC
`define RCW_REFDIV_13 4'hD
`define RCW_REF_SEL_12 2'h0
`define RCW_REF_SEL_13 2'h2
`define RCW_FAST_SHIFT 2
`define RCW_MED_SHIFT 4
`define RCW_SLOW_SHIFT 8
`define RCW_ACC_W 16
`endif

// ---- inc/rcw_pkg.sv ----
// Types of the radio control word block.
// Assumes rcw_consts.svh sits in the include path.
`include "rcw_consts.svh"
package rcw_pkg;
   // Slicer extractor phase, Gray coded along coarse -> fine -> hold
   typedef enum logic [1:0] {
      RCW_PH_COARSE = 2'h0,
      RCW_PH_FINE = 2'h1,
      RCW_PH_HOLD = 2'h3
   } rcw_phase_t;
   // Transmit power in dBm, signed
   typedef logic signed [4:0] rcw_dbm_t;
endpackage : rcw_pkg

// ---- inc/rcw_sync_if.sv ----
// Synchronised serial data, shift clock and frame strobe signals passed from the top to the shift engine.
// Assumes all signals are on mclk.
`timescale 1ns/1ns
interface rcw_sync_if;
   logic sdata;
   logic sclk_rise;
   logic strobe_lo;
   logic strobe_rise;
   logic strobe_fall;
   modport src (output sdata, output sclk_rise, output strobe_lo, output strobe_rise, output strobe_fall);
   modport dst (input sdata, input sclk_rise, input strobe_lo, input strobe_rise, input strobe_fall);
endinterface : rcw_sync_if

// ---- verilog/rcw_shift.sv ----
// Serial shift engine: keeps the last 32 bits clocked in while the frame strobe is low.
// Assumes synchronised inputs delivered through rcw_sync_if on mclk.
`timescale 1ns/1ns
`include "rcw_consts.svh"
module rcw_shift
   import rcw_pkg::*;
#(
   parameter int WORD_W = `RCW_WORD_W
)(
   input wire logic mclk,
   input wire logic rst,
   rcw_sync_if.dst sync,
   output logic [WORD_W-1:0] word,
   output logic word_load
);
   typedef struct packed {
      logic [WORD_W-1:0] shift;
      logic [WORD_W-1:0] word;
      logic load;
   } rcw_shift_st_t;
   rcw_shift_st_t s_r;
   rcw_shift_st_t s_nxt;

   // Shift while framed, latch on strobe rise
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.load = 1'b0;
      if (sync.strobe_lo && sync.sclk_rise)
      begin
         s_nxt.shift = {s_r.shift[WORD_W-2:0], sync.sdata};
      end
      if (sync.strobe_rise)
      begin
         s_nxt.word = s_r.shift;
         s_nxt.load = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_r <= '{shift: `RCW_WORD_RST, word: `RCW_WORD_RST, load: 1'b0};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign word = s_r.word;
   assign word_load = s_r.load;
endmodule : rcw_shift

// ---- verilog/rcw_slicer.sv ----
// Receive slicer level extractor: min/max coarse, integrator refine, slow hold tracking.
// Assumes demodulated samples on mclk and a synchronised timing line.
`timescale 1ns/1ns
`include "rcw_consts.svh"
module rcw_slicer
   import rcw_pkg::*;
#(
   parameter int SAMP_W = 8
)(
   input wire logic mclk,
   input wire logic rst,
   input wire logic rx_on,
   input wire logic dcx_hi,
   input wire logic dcx_mode2,
   input wire logic [SAMP_W-1:0] sample,
   output logic [SAMP_W-1:0] level,
   output rcw_phase_t phase
);
   localparam int AW = SAMP_W + `RCW_ACC_W;
   typedef struct packed {
      rcw_phase_t ph;
      logic [SAMP_W-1:0] mn;
      logic [SAMP_W-1:0] mx;
      logic [AW-1:0] acc;
   } rcw_slc_st_t;
   rcw_slc_st_t s_r;
   rcw_slc_st_t s_nxt;

   // Leaky integrator step toward the sample by 2^-k
   function automatic logic [AW-1:0] leak(input logic [AW-1:0] a, input logic [SAMP_W-1:0] x, input int k);
      logic signed [AW:0] d;
      d = $signed({1'b0, x, {`RCW_ACC_W{1'b0}}}) - $signed({1'b0, a});
      leak = AW'($signed({1'b0, a}) + (d >>> k));
   endfunction : leak

   logic [SAMP_W:0] mid;
   assign mid = (SAMP_W+1)'(s_r.mn) + (SAMP_W+1)'(s_r.mx);

   // Phase sequencing and level estimation
   always_comb
   begin
      s_nxt = s_r;
      if (!rx_on)
      begin
         s_nxt.ph = RCW_PH_COARSE;
         s_nxt.mn = '1;
         s_nxt.mx = '0;
      end
      else
      begin
         case (s_r.ph)
            RCW_PH_COARSE:
            begin
               // Fast min/max while timing line low
               if (sample < s_r.mn) s_nxt.mn = sample;
               if (sample > s_r.mx) s_nxt.mx = sample;
               s_nxt.acc = {mid[SAMP_W:1], {`RCW_ACC_W{1'b0}}};
               if (dcx_hi)
               begin
                  s_nxt.ph = RCW_PH_FINE;
               end
            end
            RCW_PH_FINE:
            begin
               // Mode 1 medium RC, mode 2 straight to slow RC
               s_nxt.acc = leak(s_r.acc, sample, dcx_mode2 ? `RCW_SLOW_SHIFT : `RCW_MED_SHIFT);
               if (!dcx_hi)
               begin
                  s_nxt.ph = RCW_PH_HOLD;
               end
            end
            RCW_PH_HOLD:
            begin
               s_nxt.acc = leak(s_r.acc, sample, `RCW_SLOW_SHIFT + `RCW_SLOW_SHIFT);
            end
            default:
            begin
               s_nxt.ph = RCW_PH_COARSE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_r <= '{ph: RCW_PH_COARSE, mn: '1, mx: '0, acc: '0};
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign level = (s_r.ph == RCW_PH_COARSE) ? mid[SAMP_W:1] : s_r.acc[AW-1:`RCW_ACC_W];
   assign phase = s_r.ph;
endmodule : rcw_slicer

// ---- verilog/rcw_top.sv ----
// Radio control word and DC extraction top: serial word capture, field decode, ramp and slicer control.
// Assumes a free running mclk; serial pins and timing line are asynchronous and synchronised here.
//
// Overview of operation
// - With bit 19 zero, timing line rise turns transmit amplifier on
// - Power spans about 17 dB, steps <=4 dB
// - PLL opens during demodulation unless held
// - Coarse min/max slicer while line low
// - Line rise seeds integrator, refines level
// - Line fall holds offset, tracks slow drift
// - Bit 19 selects transmit ramp sequence
// - Bit 18 selects DC extraction sequence
// - Bits 7..0 channel; divider 2304 plus n
// - Bits 14..13 choose divide by 12/13
// - Bits 12..10 set transmit power level
// - Bit 9 keeps PLL running all slot
// - Bit 8 one receive, zero transmit
// - Last 32 bits kept, latched on rise
// - Codes map -12 to +5 dBm
// - Mode 1 medium+slow RC, mode 2 slow
// - Ramp events per bit 19 on edges
`timescale 1ns/1ns
`include "rcw_consts.svh"
module rcw_top
   import rcw_pkg::*;
#(
   parameter int WORD_W = `RCW_WORD_W,
   parameter int SAMP_W = 8
)(
   input wire logic mclk,
   input wire logic rst,
   input wire logic serial_data,
   input wire logic serial_clk,
   input wire logic serial_frame_strobe,
   input wire logic dc_extract_ctrl,
   input wire logic [SAMP_W-1:0] demod_sample,
   output logic [WORD_W-1:0] radio_control_word,
   output logic rx_mode,
   output logic pll_on,
   output logic [11:0] main_div_ratio,
   output logic [3:0] ref_div_ratio,
   output logic ref_sel_valid,
   output logic [2:0] tx_level,
   output rcw_dbm_t tx_power_dbm,
   output logic preamp_on,
   output logic amp_on,
   output logic ant_sw_tx,
   output logic dcx_mode2,
   output logic [SAMP_W-1:0] slicer_level,
   output rcw_phase_t dcx_phase
);
   // Two-stage synchronisers plus edge history, packed as one state
   typedef struct packed {
      logic [1:0] d_s;
      logic [1:0] c_s;
      logic [1:0] e_s;
      logic [1:0] x_s;
      logic c_q;
      logic e_q;
      logic x_q;
      logic pre;
      logic amp;
      logic ant;
      logic pll;
      logic [2:0] lvl;
      logic [11:0] div;
      logic [3:0] rdiv;
      logic rvalid;
      rcw_dbm_t dbm;
   } rcw_top_st_t;
   rcw_top_st_t s_r;
   rcw_top_st_t s_nxt;
   // Strobe history starts at its idle level, so leaving reset is no false edge
   localparam rcw_top_st_t TOP_RST = '{e_s: {2{`RCW_STROBE_IDLE}}, e_q: `RCW_STROBE_IDLE, default: '0};

   rcw_sync_if sync ();
   logic [WORD_W-1:0] word;
   logic word_load;

   // Level to typical dBm, ascending table
   function automatic rcw_dbm_t lvl_dbm(input logic [2:0] c);
      case (c)
         3'h0: lvl_dbm = -5'sd12;
         3'h1: lvl_dbm = -5'sd9;
         3'h2: lvl_dbm = -5'sd6;
         3'h3: lvl_dbm = -5'sd3;
         3'h4: lvl_dbm = 5'sd0;
         3'h5: lvl_dbm = 5'sd3;
         3'h6: lvl_dbm = 5'sd4;
         default: lvl_dbm = 5'sd5;
      endcase
   endfunction : lvl_dbm

   // Reference code is one of the two known settings
   function automatic logic ref_known(input logic [1:0] code);
      ref_known = (code == `RCW_REF_SEL_12) || (code == `RCW_REF_SEL_13);
   endfunction : ref_known

   // Reference divider ratio for a known code
   function automatic logic [3:0] ref_ratio(input logic [1:0] code);
      if (code == `RCW_REF_SEL_13)
      begin
         ref_ratio = `RCW_REFDIV_13;
      end
      else
      begin
         ref_ratio = `RCW_REFDIV_12;
      end
   endfunction : ref_ratio

   // Synchronised views for the shift engine
   assign sync.sdata = s_r.d_s[1];
   assign sync.sclk_rise = s_r.c_s[1] && !s_r.c_q;
   assign sync.strobe_lo = !s_r.e_s[1];
   assign sync.strobe_rise = s_r.e_s[1] && !s_r.e_q;
   assign sync.strobe_fall = !s_r.e_s[1] && s_r.e_q;

   rcw_shift #(.WORD_W(WORD_W)) u_shift (
      .mclk(mclk),
      .rst(rst),
      .sync(sync.dst),
      .word(word),
      .word_load(word_load)
   );

   logic dcx;
   logic dcx_rise;
   logic dcx_fall;
   assign dcx = s_r.x_s[1];
   assign dcx_rise = dcx && !s_r.x_q;
   assign dcx_fall = !dcx && s_r.x_q;

   // Decode, ramp sequencing and PLL control
   always_comb
   begin
      s_nxt = s_r;
      s_nxt.d_s = {s_r.d_s[0], serial_data};
      s_nxt.c_s = {s_r.c_s[0], serial_clk};
      s_nxt.e_s = {s_r.e_s[0], serial_frame_strobe};
      s_nxt.x_s = {s_r.x_s[0], dc_extract_ctrl};
      s_nxt.c_q = s_r.c_s[1];
      s_nxt.e_q = s_r.e_s[1];
      s_nxt.x_q = s_r.x_s[1];
      if (word_load)
      begin
         s_nxt.div = `RCW_DIV_BASE + 12'(word[`RCW_CHAN_HI:`RCW_CHAN_LO]);
         s_nxt.lvl = word[`RCW_LVL_HI:`RCW_LVL_LO];
         s_nxt.dbm = lvl_dbm(word[`RCW_LVL_HI:`RCW_LVL_LO]);
         // Unknown codes keep the old divider and flag it
         s_nxt.rvalid = ref_known(word[`RCW_REF_HI_BIT:`RCW_REF_LO_BIT]);
         if (ref_known(word[`RCW_REF_HI_BIT:`RCW_REF_LO_BIT]))
         begin
            s_nxt.rdiv = ref_ratio(word[`RCW_REF_HI_BIT:`RCW_REF_LO_BIT]);
         end
      end
      // PLL closes on strobe rise, opens on fall unless held
      if (sync.strobe_rise)
      begin
         s_nxt.pll = 1'b1;
      end
      else if (sync.strobe_fall && !word[`RCW_HOLD_BIT])
      begin
         s_nxt.pll = 1'b0;
      end
      // Transmit ramp, cleared in receive
      if (word[`RCW_RX_BIT])
      begin
         s_nxt.pre = 1'b0;
         s_nxt.amp = 1'b0;
         s_nxt.ant = 1'b0;
      end
      else if (!word[`RCW_RAMP_BIT])
      begin
         // Load pulse, not the raw strobe edge: the new word must pick the sequence
         if (word_load)
         begin
            s_nxt.pre = 1'b1;
         end
         if (dcx_rise)
         begin
            s_nxt.amp = 1'b1;
         end
         if (dcx_fall)
         begin
            s_nxt.ant = 1'b1;
         end
      end
      else
      begin
         if (dcx_rise)
         begin
            s_nxt.pre = 1'b1;
         end
         if (dcx_fall)
         begin
            s_nxt.amp = 1'b1;
            s_nxt.ant = 1'b1;
         end
      end
      // New programming pulse restarts the ramp while the timing line is low
      if (sync.strobe_fall && !dcx)
      begin
         s_nxt.pre = 1'b0;
         s_nxt.amp = 1'b0;
         s_nxt.ant = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_r <= TOP_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   rcw_slicer #(.SAMP_W(SAMP_W)) u_slicer (
      .mclk(mclk),
      .rst(rst),
      .rx_on(word[`RCW_RX_BIT]),
      .dcx_hi(dcx),
      .dcx_mode2(word[`RCW_DCX_MODE_BIT]),
      .sample(demod_sample),
      .level(slicer_level),
      .phase(dcx_phase)
   );

   assign radio_control_word = word;
   assign rx_mode = word[`RCW_RX_BIT];
   assign pll_on = s_r.pll;
   assign main_div_ratio = s_r.div;
   assign ref_div_ratio = s_r.rdiv;
   assign ref_sel_valid = s_r.rvalid;
   assign tx_level = s_r.lvl;
   assign tx_power_dbm = s_r.dbm;
   assign preamp_on = s_r.pre;
   assign amp_on = s_r.amp;
   assign ant_sw_tx = s_r.ant;
   assign dcx_mode2 = word[`RCW_DCX_MODE_BIT];
endmodule : rcw_top

// ---- tb/rcw_ctrl_model.sv ----
// Baseband controller model: serial word bursts and timing line for rcw_top.
// Assumes mclk from the bench; pins change only at its falling edge.
`timescale 1ns/1ns
module rcw_ctrl_model (
   input wire logic mclk,
   output logic serial_data,
   output logic serial_clk,
   output logic serial_frame_strobe,
   output logic dc_extract_ctrl
);
   // Idle: strobe high, shift clock parked, data at pull-down level
   initial
   begin
      serial_data = 1'b0;
      serial_clk = 1'b0;
      serial_frame_strobe = 1'b1;
      dc_extract_ctrl = 1'b0;
   end
   // Half of the 160 ns shift clock period
   task automatic half;
      repeat (10) @(negedge mclk);
   endtask : half
   // Strobe fall opens a frame
   task automatic frame_open;
      serial_frame_strobe = 1'b0;
      half;
   endtask : frame_open
   // Shift n bits, MSB first, then latch
   task automatic send(input logic [63:0] w, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         serial_data = w[i];
         half;
         serial_clk = 1'b1;
         half;
         serial_clk = 1'b0;
      end
      serial_data = 1'b0;
      serial_frame_strobe = 1'b1;
      half;
      half;
   endtask : send
   // Timing line level, held for a while
   task automatic line(input logic v);
      dc_extract_ctrl = v;
      half;
      half;
   endtask : line
endmodule : rcw_ctrl_model

// ---- tb/rcw_top_monitor.sv ----
// Checker for rcw_top: field decode, ramp and PLL relations at the ports.
// Assumes binding to rcw_top; one mclk domain, rst synchronous.
`timescale 1ns/1ns
module rcw_top_monitor
   import rcw_pkg::*;
#(
   parameter int WORD_W = 32,
   parameter int SAMP_W = 8
)(
   input wire logic mclk,
   input wire logic rst,
   input wire logic dc_extract_ctrl,
   input wire logic [WORD_W-1:0] radio_control_word,
   input wire logic rx_mode,
   input wire logic pll_on,
   input wire logic [11:0] main_div_ratio,
   input wire logic [3:0] ref_div_ratio,
   input wire logic ref_sel_valid,
   input wire logic [2:0] tx_level,
   input wire rcw_dbm_t tx_power_dbm,
   input wire logic preamp_on,
   input wire logic amp_on,
   input wire logic ant_sw_tx,
   input wire logic dcx_mode2,
   input wire rcw_phase_t dcx_phase
);
   localparam rcw_dbm_t PW [8] = '{5'h14, 5'h17, 5'h1A, 5'h1D, 5'h00, 5'h03, 5'h04, 5'h05};
   logic [31:0] w;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Short name for the latched word
   assign w = radio_control_word[31:0];
   chk_chan_div: assert property ($changed(w) |=> main_div_ratio == 12'h900 + {4'h0, w[7:0]})
      else $error("divider does not follow channel");
   chk_power_map: assert property ($changed(w) |=>
      tx_level == w[12:10] && tx_power_dbm == PW[w[12:10]])
      else $error("power level decode wrong");
   chk_ref_div: assert property ($changed(w) && !w[13] |=>
      ref_sel_valid && ref_div_ratio == (w[14] ? 4'hD : 4'hC))
      else $error("reference divider wrong");
   chk_mode_bits: assert property ($changed(w) |=> rx_mode == w[8] && dcx_mode2 == w[18])
      else $error("mode bits not decoded");
   chk_rx_quiet: assert property (rx_mode [*2] |-> !preamp_on && !amp_on && !ant_sw_tx)
      else $error("ramp active in receive");
   chk_tx_coarse: assert property (!rx_mode [*3] |-> dcx_phase == RCW_PH_COARSE)
      else $error("extractor left coarse outside receive");
   chk_pll_hold: assert property ($fell(pll_on) |-> !w[9])
      else $error("PLL opened while held");
   chk_amp_line: assert property ($rose(amp_on) |-> $past(dc_extract_ctrl, 2) != w[19])
      else $error("amplifier on at wrong line edge");
   chk_ant_line: assert property ($rose(ant_sw_tx) |-> !$past(dc_extract_ctrl, 2))
      else $error("antenna switch before line fall");
endmodule : rcw_top_monitor

bind rcw_top rcw_top_monitor #(.WORD_W(WORD_W), .SAMP_W(SAMP_W)) u_mon (.mclk, .rst, .dc_extract_ctrl,
   .radio_control_word, .rx_mode, .pll_on, .main_div_ratio, .ref_div_ratio, .ref_sel_valid, .tx_level,
   .tx_power_dbm, .preamp_on, .amp_on, .ant_sw_tx, .dcx_mode2, .dcx_phase);

// ---- tb/rcw_top_tb.sv ----
// Testbench for rcw_top: word decode, power table, ramp sequences, slicer phases.
// Assumes rcw_ctrl_model as controller and rcw_top_monitor bound to the design.
`timescale 1ns/1ns
module rcw_top_tb;
   import rcw_pkg::*;
   localparam rcw_dbm_t PW [8] = '{5'h14, 5'h17, 5'h1A, 5'h1D, 5'h00, 5'h03, 5'h04, 5'h05};
   logic mclk, rst, serial_data, serial_clk, serial_frame_strobe, dc_extract_ctrl;
   logic rx_mode, pll_on, ref_sel_valid, preamp_on, amp_on, ant_sw_tx, dcx_mode2;
   logic [7:0] demod_sample, slicer_level;
   logic [31:0] radio_control_word;
   logic [11:0] main_div_ratio;
   logic [3:0] ref_div_ratio;
   logic [2:0] tx_level;
   rcw_dbm_t tx_power_dbm;
   rcw_phase_t dcx_phase;
   int n_fail = 0;
   int checked = 0;
   int cycles = 0;
   rcw_top dut (.mclk, .rst, .serial_data, .serial_clk, .serial_frame_strobe, .dc_extract_ctrl, .demod_sample,
      .radio_control_word, .rx_mode, .pll_on, .main_div_ratio, .ref_div_ratio, .ref_sel_valid, .tx_level,
      .tx_power_dbm, .preamp_on, .amp_on, .ant_sw_tx, .dcx_mode2, .slicer_level, .dcx_phase);
   rcw_ctrl_model ctrl (.mclk, .serial_data, .serial_clk, .serial_frame_strobe, .dc_extract_ctrl);
   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   // Closing report
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   // Every power code, both reference codes, channels 1F to FF, then a bad ref code
   task automatic t_fields;
      logic [2:0] l;
      logic [31:0] w;
      for (int i = 0; i < 8; i++)
      begin
         l = i[2:0];
         w = {17'h0, l[0], 1'b0, l, 2'h0, l, 5'h1F};
         ctrl.frame_open;
         check(pll_on, 0);
         ctrl.send({32'h0, w}, 32);
         check(radio_control_word, w);
         check(main_div_ratio, 12'h900 + {4'h0, l, 5'h1F});
         check(ref_div_ratio, l[0] ? 4'hD : 4'hC);
         check(tx_level, l);
         check(tx_power_dbm, PW[l]);
         check({pll_on, rx_mode}, 2'h2);
      end
      ctrl.frame_open;
      ctrl.send(64'h2000, 32);
      check({ref_sel_valid, ref_div_ratio}, 5'h0D);
      $display("t_fields done");
   endtask : t_fields
   // Leading extra bits are dropped
   task automatic t_extra;
      ctrl.frame_open;
      ctrl.send(64'hA5_0000_1C55, 40);
      check(radio_control_word, 32'h0000_1C55);
      $display("t_extra done");
   endtask : t_extra
   // Both ramp sequences across the timing line
   task automatic t_ramp;
      for (int m = 0; m < 2; m++)
      begin
         ctrl.frame_open;
         ctrl.send({32'h0, 12'h0, m[0], 19'h0}, 32);
         check({preamp_on, amp_on, ant_sw_tx}, m[0] ? 3'h0 : 3'h4);
         ctrl.line(1'b1);
         check({preamp_on, amp_on, ant_sw_tx}, m[0] ? 3'h4 : 3'h6);
         ctrl.line(1'b0);
         check({preamp_on, amp_on, ant_sw_tx}, 3'h7);
      end
      $display("t_ramp done");
   endtask : t_ramp
   // Receive in both extraction modes: coarse min/max, fine, hold; PLL held on
   task automatic t_rx;
      logic [31:0] w;
      for (int m = 0; m < 2; m++)
      begin
         w = {13'h0, m[0], 18'h0363};
         demod_sample = 8'h20;
         ctrl.frame_open;
         ctrl.send({32'h0, w}, 32);
         check({rx_mode, dcx_mode2, dcx_phase}, {1'b1, m[0], RCW_PH_COARSE});
         repeat (4) @(negedge mclk);
         demod_sample = 8'hA0;
         repeat (4) @(negedge mclk);
         check(slicer_level, 8'h60);
         ctrl.line(1'b1);
         check(dcx_phase, RCW_PH_FINE);
         check({preamp_on, amp_on, ant_sw_tx}, 3'h0);
         ctrl.line(1'b0);
         check(dcx_phase, RCW_PH_HOLD);
         // Fine phase pulls toward A0; the medium RC of mode 1 gets much further
         check(slicer_level > 8'h60, 1'b1);
         check(slicer_level > 8'h80, !m[0]);
         ctrl.frame_open;
         check(pll_on, 1);
         ctrl.send(64'h0, 0);
         check(radio_control_word, w);
         ctrl.frame_open;
         ctrl.send(64'h0, 32);
         check(dcx_phase, RCW_PH_COARSE);
      end
      $display("t_rx done");
   endtask : t_rx
   // Clock of 8 ns
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Hang limit
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         tally_and_finish;
      end
   end
   // Main sequence
   initial
   begin
      rst = 1'b1;
      demod_sample = 8'h00;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      t_fields;
      t_extra;
      t_ramp;
      t_rx;
      tally_and_finish;
   end
endmodule : rcw_top_tb
